/* hw/smq_pkg.sv */
// constants and types shared by the status and message queue block
package smq_pkg;
  // clock and synchronisation delay
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SYNC_DELAY_S = 2;
  localparam int unsigned SYNC_DELAY_CYC = SYNC_DELAY_S * CLK_HZ;
  localparam int TMR_W = 28;

  // queue sizes and widths
  localparam int IB_DEPTH = 100;
  localparam int OQ_DEPTH = 40;
  localparam int EQ_DEPTH = 10;
  localparam int BUF_DEPTH = 2;
  localparam int MSG_W = 16;
  localparam int KEY_W = 8;

  // event status register and enable mask bit positions
  localparam int ESR_PON = 7;
  localparam int ESR_CME = 5;
  localparam int ESR_EXE = 4;
  localparam int ESR_DDE = 3;
  localparam int ESR_QYE = 2;
  localparam int ESR_OPC = 0;
  localparam logic [7:0] ESE_MASK = 8'hbd;
  localparam logic [7:0] ESE_RST = 8'h00;
  localparam logic [7:0] ESR_RST = 8'h00;

  // status byte and service request enable
  localparam int STB_HW = 0;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_MSS = 6;
  localparam logic [7:0] SRE_MASK = 8'h31;
  localparam logic [7:0] SRE_RST = 8'h00;

  // response and error words
  localparam logic [15:0] ERR_TOO_MANY = 16'hfea2;
  localparam logic [15:0] RSP_ONE = 16'h0031;
  localparam logic [15:0] RSP_NONE = 16'h0000;

  // parsed commands handed over by the parser
  typedef enum logic [3:0] {
    CMD_ESE_SET, CMD_ESE_Q, CMD_ESR_Q, CMD_SRE_SET, CMD_SRE_Q, CMD_STB_Q, CMD_OPC,
    CMD_OPC_Q, CMD_WAI, CMD_RST, CMD_KEY_Q, CMD_SIM_KEY, CMD_ERR_Q
  } smq_cmd_t;
endpackage

/* hw/smq_fifo.sv */
// flip-flop fifo with flush and overwrite of the newest entry
`timescale 1ns/1ps
module smq_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2,
  parameter int CW = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // control
  input wire logic flush,
  input wire logic ovw_valid,
  // fill side
  input wire logic wr_valid,
  input wire logic [W-1:0] wr_data,
  output logic wr_ready,
  // drain side
  output logic rd_valid,
  output logic [W-1:0] rd_data,
  input wire logic rd_ready,
  // fill level
  output logic [CW-1:0] count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;

  // handshake decode
  wire push = wr_valid & wr_ready;
  wire pop = rd_valid & rd_ready;
  wire ovw = ovw_valid & (cnt_r != '0) & ~flush;
  wire [PW-1:0] wr_ptr_inc = (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
  wire [PW-1:0] rd_ptr_inc = (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
  wire [PW-1:0] last_idx = (wr_ptr_r == '0) ? PW'(DEPTH - 1) : wr_ptr_r - 1'b1;

  assign wr_ready = (cnt_r != CW'(DEPTH));
  assign rd_valid = (cnt_r != '0);
  assign rd_data = mem_r[rd_ptr_r];
  assign count = cnt_r;

  // storage carries no reset; only pointers define contents
  always_ff @(posedge ref_clk) begin
    if (push && !flush) begin
      mem_r[wr_ptr_r] <= wr_data;
    end else if (ovw) begin
      mem_r[last_idx] <= wr_data;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_inc;
      if (pop) rd_ptr_r <= rd_ptr_inc;
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end
endmodule

/* hw/smq_status_queues.sv */
// status registers, event reporting and message queues of the remote interface
`timescale 1ns/1ps
module smq_status_queues #(
  parameter int unsigned DELAY_CYC = smq_pkg::SYNC_DELAY_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // program bytes from the bus interface
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  input wire logic in_eom,
  output logic in_ready,
  // program bytes to the parser
  output logic pb_valid,
  output logic [7:0] pb_byte,
  output logic pb_eom,
  input wire logic pb_ready,
  // parsed commands
  input wire logic cmd_valid,
  input wire smq_pkg::smq_cmd_t cmd_code,
  input wire logic [7:0] cmd_arg,
  output logic cmd_ready,
  // error and event reports
  input wire logic err_valid,
  input wire logic [15:0] err_code,
  input wire logic evt_cme,
  input wire logic evt_exe,
  input wire logic evt_dde,
  input wire logic evt_qye,
  input wire logic hw_fault_pin,
  // front panel keys
  input wire logic key_valid,
  input wire logic [7:0] key_code,
  output logic sim_key_valid,
  output logic [7:0] sim_key_code,
  // responses to the talker
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  input wire logic rsp_ready,
  // status
  output logic [7:0] status_byte,
  output logic service_req
);
  typedef enum logic [1:0] {ST_IDLE, ST_OPC, ST_WAI} smq_state_t;

  smq_state_t state_r;
  smq_state_t state_nxt;
  logic opc_query_r;
  logic [smq_pkg::TMR_W-1:0] tmr_r;
  logic [7:0] ese_r;
  logic [7:0] sre_r;
  logic [7:0] esr_r;
  logic [7:0] esr_nxt;
  logic key_full_r;
  logic [7:0] key_r;
  logic after_term_r;
  logic hw_meta_r;
  logic hw_sync_r;
  logic [7:0] stb_r;
  logic srq_r;
  logic sim_valid_r;
  logic [7:0] sim_code_r;

  // fifo wiring
  logic [6:0] ib_cnt;
  logic [5:0] oq_cnt;
  logic [1:0] buf_cnt;
  logic [3:0] eq_cnt;
  logic oq_wr_ready;
  logic oq_rd_valid;
  logic [15:0] oq_rd_data;
  logic buf_wr_ready;
  logic eq_wr_ready;
  logic eq_rd_valid;
  logic [15:0] eq_rd_data;
  logic [15:0] oq_wdata;

  // input buffer ahead of the parser; back-pressure reaches the bus through in_ready
  smq_fifo #(.W(9), .DEPTH(smq_pkg::IB_DEPTH)) u_ibuf (
    .ref_clk(ref_clk), .reset_n(reset_n), .flush(1'b0), .ovw_valid(1'b0),
    .wr_valid(in_valid), .wr_data({in_eom, in_byte}), .wr_ready(in_ready),
    .rd_valid(pb_valid), .rd_data({pb_eom, pb_byte}), .rd_ready(pb_ready),
    .count(ib_cnt)
  );

  // a fresh message right after a terminator starts a new exchange
  wire in_take = in_valid & in_ready;
  wire new_msg = in_take & after_term_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      after_term_r <= 1'b1;
    end else if (in_take) begin
      after_term_r <= in_eom;
    end
  end

  // command decode; a command is taken only when idle and the queue has room
  wire cmd_take = cmd_valid & cmd_ready;
  wire is_ese_q = cmd_take & (cmd_code == smq_pkg::CMD_ESE_Q);
  wire is_esr_q = cmd_take & (cmd_code == smq_pkg::CMD_ESR_Q);
  wire is_sre_q = cmd_take & (cmd_code == smq_pkg::CMD_SRE_Q);
  wire is_stb_q = cmd_take & (cmd_code == smq_pkg::CMD_STB_Q);
  wire is_key_q = cmd_take & (cmd_code == smq_pkg::CMD_KEY_Q);
  wire is_err_q = cmd_take & (cmd_code == smq_pkg::CMD_ERR_Q);
  wire is_rst = cmd_take & (cmd_code == smq_pkg::CMD_RST);
  wire is_sim = cmd_take & (cmd_code == smq_pkg::CMD_SIM_KEY);
  wire is_opc = cmd_take & ((cmd_code == smq_pkg::CMD_OPC) | (cmd_code == smq_pkg::CMD_OPC_Q));
  wire is_wai = cmd_take & (cmd_code == smq_pkg::CMD_WAI);
  wire tmr_zero = (tmr_r == '0);
  wire opc_done = (state_r == ST_OPC) & tmr_zero & (~opc_query_r | oq_wr_ready);
  wire opc_set = opc_done & ~opc_query_r;
  wire query_push = is_ese_q | is_esr_q | is_sre_q | is_stb_q | is_key_q | is_err_q;
  wire oq_push = query_push | (opc_done & opc_query_r);

  assign cmd_ready = (state_r == ST_IDLE) & oq_wr_ready;

  // response word selection
  assign oq_wdata = is_ese_q ? {8'h00, ese_r} :
                    is_esr_q ? {8'h00, esr_r} :
                    is_sre_q ? {8'h00, sre_r} :
                    is_stb_q ? {8'h00, stb_r} :
                    is_key_q ? (key_full_r ? {8'h00, key_r} : smq_pkg::RSP_NONE) :
                    is_err_q ? (eq_rd_valid ? eq_rd_data : smq_pkg::RSP_NONE) :
                    smq_pkg::RSP_ONE;

  // synchronisation state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (is_opc) state_nxt = ST_OPC;
        else if (is_wai) state_nxt = ST_WAI;
      end
      ST_OPC: begin
        if (opc_done) state_nxt = ST_IDLE;
      end
      ST_WAI: begin
        if (tmr_zero) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE; // the spare code of the two-bit state falls back to idle
    endcase
  end

  // the two-second count is loaded on entry and runs down to zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      tmr_r <= '0;
      opc_query_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (is_opc | is_wai) begin
        tmr_r <= smq_pkg::TMR_W'(DELAY_CYC - 1);
        opc_query_r <= (cmd_code == smq_pkg::CMD_OPC_Q);
      end else if (!tmr_zero) begin
        tmr_r <= tmr_r - 1'b1;
      end
    end
  end

  // output queue then a two-entry buffer toward the talker
  smq_fifo #(.W(smq_pkg::MSG_W), .DEPTH(smq_pkg::OQ_DEPTH)) u_oq (
    .ref_clk(ref_clk), .reset_n(reset_n), .flush(new_msg), .ovw_valid(1'b0),
    .wr_valid(oq_push), .wr_data(oq_wdata), .wr_ready(oq_wr_ready),
    .rd_valid(oq_rd_valid), .rd_data(oq_rd_data), .rd_ready(buf_wr_ready),
    .count(oq_cnt)
  );

  smq_fifo #(.W(smq_pkg::MSG_W), .DEPTH(smq_pkg::BUF_DEPTH)) u_rbuf (
    .ref_clk(ref_clk), .reset_n(reset_n), .flush(new_msg), .ovw_valid(1'b0),
    .wr_valid(oq_rd_valid), .wr_data(oq_rd_data), .wr_ready(buf_wr_ready),
    .rd_valid(rsp_valid), .rd_data(rsp_data), .rd_ready(rsp_ready),
    .count(buf_cnt)
  );

  // error queue; when full the newest entry is overlaid instead of losing old ones
  wire eq_full = ~eq_wr_ready;
  smq_fifo #(.W(16), .DEPTH(smq_pkg::EQ_DEPTH)) u_eq (
    .ref_clk(ref_clk), .reset_n(reset_n), .flush(1'b0), .ovw_valid(err_valid & eq_full),
    .wr_valid(err_valid), .wr_data(eq_full ? smq_pkg::ERR_TOO_MANY : err_code), .wr_ready(eq_wr_ready),
    .rd_valid(eq_rd_valid), .rd_data(eq_rd_data), .rd_ready(is_err_q),
    .count(eq_cnt)
  );

  // enable registers keep only their defined bits
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ese_r <= smq_pkg::ESE_RST;
      sre_r <= smq_pkg::SRE_RST;
    end else if (cmd_take) begin
      if (cmd_code == smq_pkg::CMD_ESE_SET) ese_r <= cmd_arg & smq_pkg::ESE_MASK;
      if (cmd_code == smq_pkg::CMD_SRE_SET) sre_r <= cmd_arg & smq_pkg::SRE_MASK;
    end
  end

  // event register: a new event in the read cycle survives the clear
  wire [7:0] esr_set = (8'(evt_cme) << smq_pkg::ESR_CME) | (8'(evt_exe) << smq_pkg::ESR_EXE) |
                       (8'(evt_dde) << smq_pkg::ESR_DDE) | (8'(evt_qye) << smq_pkg::ESR_QYE) |
                       (8'(opc_set) << smq_pkg::ESR_OPC);
  assign esr_nxt = (is_esr_q ? 8'h00 : esr_r) | esr_set;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      esr_r <= smq_pkg::ESR_RST;
    end else begin
      esr_r <= esr_nxt;
    end
  end

  // hardware fault pin comes from outside, so two flops first
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hw_meta_r <= 1'b0;
      hw_sync_r <= 1'b0;
    end else begin
      hw_meta_r <= hw_fault_pin;
      hw_sync_r <= hw_meta_r;
    end
  end

  // status byte assembly; summary excludes bit six itself
  wire mav = (oq_cnt != '0) | (buf_cnt != '0);
  wire esb = |(esr_r & ese_r);
  wire [7:0] stb_low = (8'(hw_sync_r) << smq_pkg::STB_HW) | (8'(mav) << smq_pkg::STB_MAV) |
                       (8'(esb) << smq_pkg::STB_ESB);
  wire mss = |(stb_low & sre_r);
  wire [7:0] stb_nxt = stb_low | (8'(mss) << smq_pkg::STB_MSS);

  // registered to keep the outputs glitch free; one cycle behind its sources
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stb_r <= 8'h00;
      srq_r <= 1'b0;
    end else begin
      stb_r <= stb_nxt;
      srq_r <= mss;
    end
  end

  assign status_byte = stb_r;
  assign service_req = srq_r;

  // one-deep key queue; a press while full is dropped so the first key is kept,
  // but a press in the very cycle of a key query refills the emptied slot (set wins)
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      key_full_r <= 1'b0;
      key_r <= 8'h00;
    end else if (is_rst) begin
      key_full_r <= 1'b0;
    end else if (key_valid && (!key_full_r || is_key_q)) begin
      key_full_r <= 1'b1;
      key_r <= key_code;
    end else if (is_key_q) begin
      key_full_r <= 1'b0;
    end
  end

  // simulated keys go to the panel logic only, never into the key queue
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sim_valid_r <= 1'b0;
      sim_code_r <= 8'h00;
    end else begin
      sim_valid_r <= is_sim;
      if (is_sim) sim_code_r <= cmd_arg;
    end
  end

  assign sim_key_valid = sim_valid_r;
  assign sim_key_code = sim_code_r;

  // checks
  AST_ESE_LAYOUT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ese_r & ~smq_pkg::ESE_MASK) == 8'h00) else $error("enable mask holds an undefined bit");
  AST_ESE_QUERY_KEEP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_ese_q |-> oq_wdata == {8'h00, ese_r} ##1 $stable(ese_r)) else $error("mask query altered mask");
  AST_IB_BOUND: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ib_cnt == 7'd100 |-> !in_ready) else $error("input buffer accepts past 100 bytes");
  AST_OQ_BOUND: assert property (@(posedge ref_clk) disable iff (!reset_n)
    oq_cnt == 6'd40 |-> !cmd_ready) else $error("command taken with output queue full");
  AST_MAV: assert property (@(posedge ref_clk) disable iff (!reset_n)
    oq_push && !new_msg |=> ##1 status_byte[4]) else $error("message available not raised");
  AST_FLUSH: assert property (@(posedge ref_clk) disable iff (!reset_n)
    new_msg |=> (oq_cnt == 6'd0) && !rsp_valid ##1 !status_byte[4]) else $error("output not flushed");
  AST_EQ_BOUND: assert property (@(posedge ref_clk) disable iff (!reset_n)
    eq_cnt <= 4'd10) else $error("error queue above ten");
  AST_EQ_OVF: assert property (@(posedge ref_clk) disable iff (!reset_n)
    err_valid && eq_cnt == 4'd10 && !is_err_q |=> eq_cnt == 4'd10) else $error("overflow changed depth");
  AST_SIM_KEY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_sim && !key_valid && !key_full_r |=> !key_full_r) else $error("simulated key entered queue");
  AST_KEY_EMPTY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_key_q && !key_full_r |-> oq_wdata == 16'h0000) else $error("empty key query not zero");
  AST_KEY_RST: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_rst |=> !key_full_r) else $error("reset command left a key");
  AST_SEQ: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !tmr_zero |-> !cmd_take) else $error("command taken while busy");
  AST_OPC_WAIT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(esr_r[smq_pkg::ESR_OPC]) |-> $past(state_r) == ST_OPC && $past(tmr_zero)) else $error("early opc");
  AST_WAI_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_wai |=> !cmd_ready [*2]) else $error("wait released too soon");
  AST_ESR_CLR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_esr_q && esr_set == 8'h00 |=> esr_r == 8'h00) else $error("event register not cleared");
  AST_ESB: assert property (@(posedge ref_clk) disable iff (!reset_n)
    esr_r[4] && ese_r[4] |=> status_byte[5]) else $error("summary bit missing");
endmodule

/* dv/smq_bus_ctl.sv */
// bus controller model: offers program bytes and takes query responses
`timescale 1ns/1ps
module smq_bus_ctl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // pace of response taking
  input wire logic slow,
  // program bytes towards the device
  output logic in_valid,
  output logic [7:0] in_byte,
  output logic in_eom,
  input wire logic in_ready,
  // responses from the device
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  output logic rsp_ready
);
  // idle bus at time zero
  initial begin
    in_valid = 1'b0;
    in_byte = 8'h00;
    in_eom = 1'b0;
    rsp_ready = 1'b0;
  end

  // offer one byte, hold it until the edge that takes it; give up if refused
  task automatic send(input logic [7:0] b, input logic eom, output logic ok);
    int i;
    ok = 1'b0;
    @(negedge ref_clk);
    in_valid = 1'b1;
    in_byte = b;
    in_eom = eom;
    for (i = 0; i < 50 && in_ready !== 1'b1; i++) @(negedge ref_clk);
    if (in_ready === 1'b1) begin
      ok = 1'b1;
      @(posedge ref_clk);
      @(negedge ref_clk);
    end
    // released lines show the inverse so a stale byte cannot pass
    in_valid = 1'b0;
    in_byte = ~b;
    in_eom = ~eom;
  endtask

  // take one response; a slow controller waits before it is ready
  task automatic take(output logic [15:0] d, output logic ok);
    int i;
    ok = 1'b0;
    d = 16'hxxxx;
    @(negedge ref_clk);
    if (slow) repeat (3) @(negedge ref_clk);
    rsp_ready = 1'b1;
    for (i = 0; i < 60 && rsp_valid !== 1'b1; i++) @(negedge ref_clk);
    if (rsp_valid === 1'b1) begin
      ok = 1'b1;
      d = rsp_data;
      @(posedge ref_clk);
      @(negedge ref_clk);
    end
    rsp_ready = 1'b0;
  endtask
endmodule

/* dv/smq_status_queues_tb.sv */
// self-checking bench for the status and message queue block
`timescale 1ns/1ps
module smq_status_queues_tb;
  localparam int DLY = 20;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic slow = 1'b0;
  logic pb_ready = 1'b0;
  logic cmd_valid = 1'b0;
  smq_pkg::smq_cmd_t cmd_code = smq_pkg::CMD_STB_Q;
  logic [7:0] cmd_arg = 8'h00;
  logic err_valid = 1'b0;
  logic [15:0] err_code = 16'h0000;
  logic [3:0] evt = 4'h0;
  logic hw_fault_pin = 1'b0;
  logic key_valid = 1'b0;
  logic [7:0] key_code = 8'h00;
  logic in_valid, in_eom, in_ready, pb_valid, pb_eom, cmd_ready, sim_key_valid, rsp_valid, rsp_ready, service_req;
  logic [7:0] in_byte, pb_byte, sim_key_code, status_byte, sim_code;
  logic [15:0] rsp_data;
  int failures = 0;
  int check_count = 0;
  int sim_seen = 0;

  // short delay so the two-second waits stay cheap
  smq_status_queues #(.DELAY_CYC(DLY)) i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .in_valid(in_valid), .in_byte(in_byte), .in_eom(in_eom), .in_ready(in_ready),
    .pb_valid(pb_valid), .pb_byte(pb_byte), .pb_eom(pb_eom), .pb_ready(pb_ready),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
    .err_valid(err_valid), .err_code(err_code), .evt_cme(evt[3]), .evt_exe(evt[2]),
    .evt_dde(evt[1]), .evt_qye(evt[0]), .hw_fault_pin(hw_fault_pin),
    .key_valid(key_valid), .key_code(key_code), .sim_key_valid(sim_key_valid), .sim_key_code(sim_key_code),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
    .status_byte(status_byte), .service_req(service_req)
  );

  smq_bus_ctl i_ctl (
    .ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
    .in_valid(in_valid), .in_byte(in_byte), .in_eom(in_eom), .in_ready(in_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready)
  );

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;

  // simulated key presses leave the block on their own strobe
  always @(posedge ref_clk) begin
    if (sim_key_valid === 1'b1) begin
      sim_seen++;
      sim_code <= sim_key_code;
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // command handshake: hold until the edge with cmd_ready high
  task automatic cmd(input smq_pkg::smq_cmd_t c, input logic [7:0] a);
    int i;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_arg = a;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
    chk("cmd accepted", {15'h0, cmd_ready}, 16'h0001);
    @(posedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd_arg = ~a;
  endtask

  task automatic query(input string nm, input smq_pkg::smq_cmd_t c, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    cmd(c, 8'h00);
    i_ctl.take(d, ok);
    chk(nm, d, exp);
  endtask

  // one-cycle strobes of the event, error and key sources
  task automatic pulse_evt(input logic [3:0] m);
    @(negedge ref_clk);
    evt = m;
    @(negedge ref_clk);
    evt = 4'h0;
  endtask

  task automatic err(input logic [15:0] c);
    @(negedge ref_clk);
    err_valid = 1'b1;
    err_code = c;
    @(negedge ref_clk);
    err_valid = 1'b0;
  endtask

  task automatic key(input logic [7:0] k);
    @(negedge ref_clk);
    key_valid = 1'b1;
    key_code = k;
    @(negedge ref_clk);
    key_valid = 1'b0;
  endtask

  // head of the input buffer: valid flag, end flag and byte
  task automatic pop(input logic [8:0] exp);
    @(negedge ref_clk);
    chk("pb head", {6'h0, pb_valid, pb_eom, pb_byte}, {6'h0, 1'b1, exp});
    pb_ready = 1'b1;
    @(negedge ref_clk);
    pb_ready = 1'b0;
  endtask

  // cycles that cmd_ready stays low after a synchronising command
  task automatic busy_len(output int n);
    n = 0;
    while (cmd_ready !== 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  task automatic summarize();
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    int i;
    int n;
    logic ok;
    logic [15:0] d;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("reset flags", {status_byte, 3'h0, service_req, in_ready, cmd_ready, pb_valid, rsp_valid}, 16'h000c);
    reset_n = 1'b1;
    query("ese reset", smq_pkg::CMD_ESE_Q, 16'h0000);
    query("sre reset", smq_pkg::CMD_SRE_Q, 16'h0000);
    query("err reset", smq_pkg::CMD_ERR_Q, 16'h0000);
    cmd(smq_pkg::CMD_ESE_SET, 8'hff);
    query("ese all", smq_pkg::CMD_ESE_Q, 16'h00bd);
    query("ese again", smq_pkg::CMD_ESE_Q, 16'h00bd);
    cmd(smq_pkg::CMD_ESE_SET, 8'h42);
    query("ese unused", smq_pkg::CMD_ESE_Q, 16'h0000);
    // enabled events raise the summary; reading the register clears it
    cmd(smq_pkg::CMD_ESE_SET, 8'h3c);
    pulse_evt(4'hf);
    cyc(3);
    chk("esb set", status_byte[5], 1'b1);
    query("esr", smq_pkg::CMD_ESR_Q, 16'h003c);
    query("esr cleared", smq_pkg::CMD_ESR_Q, 16'h0000);
    cyc(3);
    chk("esb clear", status_byte[5], 1'b0);
    cmd(smq_pkg::CMD_ESE_SET, 8'h00);
    pulse_evt(4'h1);
    cyc(3);
    chk("esb masked", status_byte[5], 1'b0);
    query("esr qye", smq_pkg::CMD_ESR_Q, 16'h0004);
    // hardware summary and service request
    cmd(smq_pkg::CMD_SRE_SET, 8'hff);
    query("sre", smq_pkg::CMD_SRE_Q, 16'h0031);
    hw_fault_pin = 1'b1;
    cyc(5);
    chk("stb hw", {status_byte, 7'h0, service_req}, 16'h4101);
    hw_fault_pin = 1'b0;
    cyc(5);
    chk("stb idle", status_byte, 8'h00);
    // fill the input buffer until refused, then drain in order
    for (i = 0; i < 100; i++) begin
      i_ctl.send(i[7:0], i == 99, ok);
      chk("in take", ok, 1'b1);
    end
    i_ctl.send(8'hee, 1'b0, ok);
    chk("in full", ok, 1'b0);
    for (i = 0; i < 100; i++) pop({i == 99, i[7:0]});
    cyc(1);
    chk("pb empty", pb_valid, 1'b0);
    // a byte after a terminator flushes pending answers
    cmd(smq_pkg::CMD_STB_Q, 8'h00);
    cyc(4);
    chk("mav", status_byte[4], 1'b1);
    i_ctl.send(8'h55, 1'b0, ok);
    cyc(4);
    chk("flushed", {status_byte[4], rsp_valid}, 2'b00);
    pop({1'b0, 8'h55});
    cmd(smq_pkg::CMD_STB_Q, 8'h00);
    i_ctl.send(8'h56, 1'b0, ok);
    cyc(4);
    chk("kept", rsp_valid, 1'b1);
    i_ctl.take(d, ok);
    pop({1'b0, 8'h56});
    // output path holds 40 queued plus the two-entry buffer
    for (i = 0; i < 42; i++) cmd(smq_pkg::CMD_STB_Q, 8'h00);
    cyc(3);
    chk("oq full", {status_byte[4], cmd_ready}, 2'b10);
    slow = 1'b1;
    for (i = 0; i < 42; i++) begin
      i_ctl.take(d, ok);
      chk("oq drain", ok, 1'b1);
    end
    slow = 1'b0;
    cyc(4);
    chk("oq empty", {status_byte[4], rsp_valid}, 2'b00);
    // error queue overflow keeps the oldest and marks the newest
    for (i = 0; i < 12; i++) err(16'h0100 + i[15:0]);
    for (i = 0; i < 9; i++) query("err", smq_pkg::CMD_ERR_Q, 16'h0100 + i[15:0]);
    query("err overflow", smq_pkg::CMD_ERR_Q, 16'hfea2);
    query("err empty", smq_pkg::CMD_ERR_Q, 16'h0000);
    // key queue: simulated keys stay out, one deep, reset empties
    cmd(smq_pkg::CMD_SIM_KEY, 8'h33);
    cyc(2);
    chk("sim key", {sim_seen[7:0], sim_code}, 16'h0133);
    query("key sim", smq_pkg::CMD_KEY_Q, 16'h0000);
    key(8'h11);
    key(8'h22);
    query("key first", smq_pkg::CMD_KEY_Q, 16'h0011);
    query("key empty", smq_pkg::CMD_KEY_Q, 16'h0000);
    key(8'h44);
    cmd(smq_pkg::CMD_RST, 8'h00);
    query("key rst", smq_pkg::CMD_KEY_Q, 16'h0000);
    // synchronising commands hold the command stream
    cmd(smq_pkg::CMD_OPC, 8'h00);
    busy_len(n);
    chk("opc hold", n >= DLY - 2 && n <= DLY + 1, 1'b1);
    query("opc bit", smq_pkg::CMD_ESR_Q, 16'h0001);
    query("opc query", smq_pkg::CMD_OPC_Q, 16'h0031);
    cmd(smq_pkg::CMD_WAI, 8'h00);
    busy_len(n);
    chk("wai hold", n >= DLY - 2 && n <= DLY + 1, 1'b1);
    // second reset in mid-run
    cmd(smq_pkg::CMD_ESE_SET, 8'h01);
    key(8'h66);
    reset_n = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    query("ese rerst", smq_pkg::CMD_ESE_Q, 16'h0000);
    query("key rerst", smq_pkg::CMD_KEY_Q, 16'h0000);
    summarize();
  end

  // the whole sequence needs well under 10000 cycles
  initial begin
    #(8 * 20000);
    failures++;
    summarize();
  end
endmodule
